// *** design/adcsc_top.sv ***
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Ten-bit successive approximation result per sample
// - Conversion end raises end interrupt request
// - Interrupt passes only while enable bit set
// - Start only after calibration done reads one
// - Channel codes 000 to 100 select inputs
// - Clock codes divide eight, four, two, timer
// - Start bit high while running, self clears
// - Result in bits 15..6 of channel register
module adcsc_top
   import adcsc_pkg::*;
#(
   parameter int CAL_CYCLES_P = CAL_CYCLES
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Avalon-MM slave
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Interrupt
   output logic irq_o,
   // Converter analog front end
   input wire logic timer_tick_i,
   input wire logic comp_i,
   output logic [2:0] chan_mux_o,
   output logic [RES_BITS-1:0] dac_code_o,
   output logic sample_o,
   output logic power_down_o
);
   // Control and status
   logic end_flag_reg, end_flag_next;
   logic start_reg, start_next;
   logic irq_en_reg, irq_en_next;
   logic [1:0] clk_sel_reg, clk_sel_next;
   logic [2:0] chan_reg, chan_next;
   logic [2:0] conv_chan_reg, conv_chan_next;
   logic power_save_reg, power_save_next;
   logic cal_done_reg, cal_done_next;
   logic [31:0] cal_cnt_reg, cal_cnt_next;
   logic int_stat_reg, int_stat_next;
   logic int_mask_reg, int_mask_next;
   logic irq_reg, irq_next;
   logic [15:0] result_reg [NUM_CHAN];
   // Bus
   logic ack_reg, ack_next;
   logic wait_reg, wait_next;
   logic [31:0] rdata_reg, rdata_next;
   // Converter clock
   logic [2:0] div_reg, div_next;
   logic tick;
   logic sar_start, sar_abort, sar_done;
   logic [RES_BITS-1:0] sar_result;
   logic wr_en;
   logic [7:0] ctrl_rd;

   //////////////////////////////////////////////////////////////////////////
   // Bus handshake: every access answers one cycle after it is seen
   assign wr_en = avs_write_i & ack_reg;
   assign ctrl_rd = {end_flag_reg, start_reg, irq_en_reg, clk_sel_reg, chan_reg};

   always_comb
   begin
      ack_next = (avs_read_i | avs_write_i) & ~ack_reg;
      // Own flop for waitrequest so the pin carries no gate after the register
      wait_next = ~ack_next;
      rdata_next = rdata_reg;
      if (avs_read_i & ~ack_reg)
      begin
         rdata_next = 32'h0000_0000;
         case (avs_address_i)
            OFS_CTRL_STATUS: rdata_next[7:0] = ctrl_rd;
            OFS_POWER_CTRL:
            begin
               rdata_next[POS_POWER_SAVE] = power_save_reg;
               rdata_next[POS_CAL_DONE] = cal_done_reg;
            end
            OFS_INT_STATUS: rdata_next[0] = int_stat_reg;
            OFS_INT_MASK: rdata_next[0] = int_mask_reg;
            default:
            begin
               // Result window; anything unmapped reads zero
               for (int i = 0; i < NUM_CHAN; i++)
               begin
                  if (avs_address_i == OFS_RESULT0 + 6'(4 * i))
                  begin
                     rdata_next[15:0] = result_reg[i];
                  end
               end
            end
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= ack_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Converter clock enable from the system clock or the timer
   always_comb
   begin
      div_next = div_reg + 3'h1;
      tick = 1'b0;
      case (clk_sel_reg)
         CKS_DIV8: tick = (div_reg == 3'h7);
         CKS_DIV4: tick = (div_reg[1:0] == 2'h3);
         CKS_DIV2: tick = div_reg[0];
         CKS_TIMER: tick = timer_tick_i;
         default: tick = 1'b0;
      endcase
      // Restart the divider with each conversion so the first period is whole
      if (sar_start)
      begin
         div_next = 3'h0;
      end
   end

   // Divider register
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         div_reg <= 3'h0;
      end
      else
      begin
         div_reg <= div_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Power save, calibration and control register
   assign sar_start = wr_en && avs_address_i == OFS_CTRL_STATUS && avs_writedata_i[POS_START]
                      && !start_reg && !power_save_reg && cal_done_reg;
   assign sar_abort = wr_en && avs_address_i == OFS_CTRL_STATUS && !avs_writedata_i[POS_START];

   always_comb
   begin
      power_save_next = power_save_reg;
      cal_done_next = cal_done_reg;
      cal_cnt_next = cal_cnt_reg;
      end_flag_next = end_flag_reg;
      start_next = start_reg;
      irq_en_next = irq_en_reg;
      clk_sel_next = clk_sel_reg;
      chan_next = chan_reg;
      conv_chan_next = conv_chan_reg;
      int_stat_next = int_stat_reg;
      int_mask_next = int_mask_reg;
      if (wr_en && avs_address_i == OFS_POWER_CTRL)
      begin
         power_save_next = avs_writedata_i[POS_POWER_SAVE];
      end
      // Calibration restarts whenever the converter is powered down
      if (power_save_reg)
      begin
         cal_cnt_next = 32'h0000_0000;
         cal_done_next = 1'b0;
      end
      else if (!cal_done_reg)
      begin
         cal_cnt_next = cal_cnt_reg + 32'h0000_0001;
         if (cal_cnt_reg == 32'(CAL_CYCLES_P - 1))
         begin
            cal_done_next = 1'b1;
         end
      end
      if (wr_en && avs_address_i == OFS_CTRL_STATUS)
      begin
         // Fields are frozen mid-conversion so the running sample stays coherent
         if (!start_reg)
         begin
            irq_en_next = avs_writedata_i[POS_IRQ_EN];
            clk_sel_next = avs_writedata_i[POS_CLK_LSB +: 2];
            chan_next = avs_writedata_i[POS_CHAN_LSB +: 3];
         end
         if (!avs_writedata_i[POS_END_FLAG])
         begin
            end_flag_next = 1'b0;
         end
         if (sar_abort)
         begin
            start_next = 1'b0;
         end
      end
      if (sar_start)
      begin
         start_next = 1'b1;
         conv_chan_next = avs_writedata_i[POS_CHAN_LSB +: 3];
      end
      if (wr_en && avs_address_i == OFS_INT_STATUS && avs_writedata_i[0])
      begin
         int_stat_next = 1'b0;
      end
      if (wr_en && avs_address_i == OFS_INT_MASK)
      begin
         int_mask_next = avs_writedata_i[0];
      end
      // Set beats clear when the end lands on a clearing write
      if (sar_done)
      begin
         start_next = 1'b0;
         end_flag_next = 1'b1;
         int_stat_next = 1'b1;
      end
      irq_next = int_stat_next & int_mask_next & irq_en_next;
   end

   // Control registers
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         power_save_reg <= RST_POWER_SAVE;
         cal_done_reg <= 1'b0;
         cal_cnt_reg <= 32'h0000_0000;
         end_flag_reg <= RST_CTRL_STATUS[POS_END_FLAG];
         start_reg <= RST_CTRL_STATUS[POS_START];
         irq_en_reg <= RST_CTRL_STATUS[POS_IRQ_EN];
         clk_sel_reg <= RST_CTRL_STATUS[POS_CLK_LSB +: 2];
         chan_reg <= RST_CTRL_STATUS[POS_CHAN_LSB +: 3];
         conv_chan_reg <= 3'h0;
         int_stat_reg <= 1'b0;
         int_mask_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         power_save_reg <= power_save_next;
         cal_done_reg <= cal_done_next;
         cal_cnt_reg <= cal_cnt_next;
         end_flag_reg <= end_flag_next;
         start_reg <= start_next;
         irq_en_reg <= irq_en_next;
         clk_sel_reg <= clk_sel_next;
         chan_reg <= chan_next;
         conv_chan_reg <= conv_chan_next;
         int_stat_reg <= int_stat_next;
         int_mask_reg <= int_mask_next;
         irq_reg <= irq_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Result registers, one per channel, written with the end flag
   for (genvar g = 0; g < NUM_CHAN; g++)
   begin : g_res
      logic [15:0] res_next;
      always_comb
      begin
         res_next = result_reg[g];
         if (sar_done && conv_chan_reg == 3'(g))
         begin
            res_next = {sar_result, {RES_SHIFT{1'b0}}};
         end
      end
      always_ff @(posedge ref_clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            result_reg[g] <= RST_RESULT;
         end
         else
         begin
            result_reg[g] <= res_next;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Successive approximation engine
   adcsc_sar u_sar
   (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .start_i(sar_start),
      .abort_i(sar_abort),
      .comp_i(comp_i),
      .trial_o(dac_code_o),
      .sample_o(sample_o),
      .busy_o(),
      .done_o(sar_done),
      .result_o(sar_result)
   );

   // Outputs straight from flops
   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign irq_o = irq_reg;
   assign chan_mux_o = conv_chan_reg;
   assign power_down_o = power_save_reg;
endmodule

// *** design/adcsc_pkg.sv ***
package adcsc_pkg;
   // Register byte offsets on the Avalon slave
   localparam logic [5:0] OFS_CTRL_STATUS = 6'h00;
   localparam logic [5:0] OFS_POWER_CTRL = 6'h04;
   localparam logic [5:0] OFS_RESULT0 = 6'h08;
   localparam logic [5:0] OFS_INT_STATUS = 6'h1c;
   localparam logic [5:0] OFS_INT_MASK = 6'h20;
   // Field positions in conv_ctrl_status
   localparam int POS_END_FLAG = 7;
   localparam int POS_START = 6;
   localparam int POS_IRQ_EN = 5;
   localparam int POS_CLK_LSB = 3;
   localparam int POS_CHAN_LSB = 0;
   // Field positions in conv_power_ctrl
   localparam int POS_POWER_SAVE = 0;
   localparam int POS_CAL_DONE = 1;
   // Result placement
   localparam int RES_BITS = 10;
   localparam int RES_SHIFT = 6;
   localparam int NUM_CHAN = 5;
   // Reset values
   localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
   localparam logic RST_POWER_SAVE = 1'b1;
   localparam logic [15:0] RST_RESULT = 16'h0000;
   // Clock select codes
   localparam logic [1:0] CKS_DIV8 = 2'h0;
   localparam logic [1:0] CKS_DIV4 = 2'h1;
   localparam logic [1:0] CKS_DIV2 = 2'h2;
   localparam logic [1:0] CKS_TIMER = 2'h3;
   // Timing
   localparam int CLK_HZ = 20000000;
   localparam int T_CAL_MS = 22;
   localparam int CAL_CYCLES = T_CAL_MS * (CLK_HZ / 1000);
   // Conversion sequencer states
   typedef enum logic [2:0]
   {
      SAR_IDLE = 3'b001,
      SAR_SAMPLE = 3'b010,
      SAR_CONV = 3'b100
   } adcsc_sar_state_t;
endpackage

// *** design/adcsc_sar.sv ***
`timescale 1ns/1ns
module adcsc_sar
   import adcsc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Control
   input wire logic tick_i,
   input wire logic start_i,
   input wire logic abort_i,
   // Analog side
   input wire logic comp_i,
   output logic [RES_BITS-1:0] trial_o,
   output logic sample_o,
   // Results
   output logic busy_o,
   output logic done_o,
   output logic [RES_BITS-1:0] result_o
);
   adcsc_sar_state_t state_reg, state_next;
   logic [RES_BITS-1:0] code_reg, code_next;
   logic [3:0] idx_reg, idx_next;
   logic done_reg, done_next;
   logic [RES_BITS-1:0] res_reg, res_next;
   logic [RES_BITS-1:0] decided;

   ////////////////////////////////////////////////////////////////////////
   // Binary search: one bit decided per converter clock tick
   always_comb
   begin
      state_next = state_reg;
      code_next = code_reg;
      idx_next = idx_reg;
      done_next = 1'b0;
      res_next = res_reg;
      decided = code_reg;
      decided[idx_reg] = comp_i;
      case (state_reg)
         SAR_IDLE:
         begin
            if (start_i)
            begin
               state_next = SAR_SAMPLE;
            end
         end
         SAR_SAMPLE:
         begin
            // Hold the input for one full divided clock, or until the next timer tick, before trials
            if (abort_i)
            begin
               state_next = SAR_IDLE;
            end
            else if (tick_i)
            begin
               state_next = SAR_CONV;
               idx_next = 4'(RES_BITS - 1);
               code_next = {1'b1, {(RES_BITS-1){1'b0}}};
            end
         end
         SAR_CONV:
         begin
            if (abort_i)
            begin
               state_next = SAR_IDLE;
               code_next = '0;
            end
            else if (tick_i)
            begin
               if (idx_reg == 4'h0)
               begin
                  state_next = SAR_IDLE;
                  res_next = decided;
                  done_next = 1'b1;
                  code_next = '0;
               end
               else
               begin
                  code_next = decided;
                  code_next[idx_reg - 4'h1] = 1'b1;
                  idx_next = idx_reg - 4'h1;
               end
            end
         end
         default:
         begin
            state_next = SAR_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_reg <= SAR_IDLE;
         code_reg <= '0;
         idx_reg <= 4'h0;
         done_reg <= 1'b0;
         res_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         code_reg <= code_next;
         idx_reg <= idx_next;
         done_reg <= done_next;
         res_reg <= res_next;
      end
   end

   assign trial_o = code_reg;
   // One-hot bit of the sample state, taken straight from its flop
   assign sample_o = state_reg[1];
   assign busy_o = (state_reg != SAR_IDLE);
   assign done_o = done_reg;
   assign result_o = res_reg;
endmodule

// *** bench/adcsc_assertions.sv ***
`timescale 1ns/1ns
module adcsc_assertions
   import adcsc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Bus handshake
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   // Interrupt and converter side
   input wire logic irq_o,
   input wire logic [2:0] chan_mux_o,
   input wire logic [RES_BITS-1:0] dac_code_o,
   input wire logic sample_o,
   input wire logic power_down_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////////////////////////
   // Sample phase ends on its own, not through an abort write
   sequence s_sample_end;
      $fell(sample_o) && $past(avs_waitrequest_o);
   endsequence
   // First trial is the top bit alone
   sequence s_msb_trial;
      ##[0:1] dac_code_o == 10'h200;
   endsequence

   // Bus answer comes one cycle after the request and lasts one cycle
   a_idle_wait_high: assert property (!avs_read_i && !avs_write_i |-> avs_waitrequest_o)
      else $error("waitrequest low with no request");
   a_answer_next: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer late");
   a_answer_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   // Converter starts powered down and quiet
   a_reset_state: assert property ($fell(rst_i) |-> power_down_o && !irq_o && !sample_o)
      else $error("bad state after reset");
   a_msb_first: assert property (s_sample_end |-> s_msb_trial)
      else $error("first trial not the top bit");
   a_power_quiet: assert property (power_down_o |-> !sample_o && dac_code_o == '0)
      else $error("converter active while powered down");
   // Channel must not move under a running conversion
   a_chan_hold: assert property (sample_o && $past(sample_o) || dac_code_o != '0 && $past(dac_code_o) != '0
      |-> $stable(chan_mux_o))
      else $error("channel changed mid conversion");
   a_sample_short: assert property ($rose(sample_o) |-> ##[1:40] !sample_o)
      else $error("sample phase too long");
   // Request only drops after a software write; the flop follows the accepting edge directly
   a_irq_drop: assert property ($fell(irq_o) |-> $past(avs_write_i && !avs_waitrequest_o))
      else $error("interrupt dropped without a write");
endmodule

// *** bench/adcsc_analog_model.sv ***
`timescale 1ns/1ns
module adcsc_analog_model
   import adcsc_pkg::*;
(
   // Clock
   input wire logic ref_clk_i,
   // Input levels, ten bits per channel
   input wire logic [NUM_CHAN*RES_BITS-1:0] level_i,
   // Converter side
   input wire logic [2:0] chan_i,
   input wire logic [RES_BITS-1:0] dac_i,
   input wire logic sample_i,
   output logic comp_o
);
   logic [RES_BITS-1:0] held = '0;
   // Track while sampling, hold after; unused codes keep the old level
   always @(posedge ref_clk_i)
      if (sample_i && chan_i < NUM_CHAN)
         held <= level_i[chan_i*RES_BITS +: RES_BITS];
   // Comparator high while the held level is at or above the trial
   assign comp_o = (held >= dac_i);
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top
   import adcsc_pkg::*;
;
   // Short calibration keeps the run brief
   localparam int CAL_SIM = 20;
   // Design side
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [5:0] avs_address_i = 6'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic irq_o;
   logic timer_tick_i = 1'b0;
   logic comp_i;
   logic [2:0] chan_mux_o;
   logic [RES_BITS-1:0] dac_code_o;
   logic sample_o;
   logic power_down_o;
   // Bench state
   logic [NUM_CHAN*RES_BITS-1:0] level = '0;
   logic [1:0] tick_cnt = 2'h0;
   logic [31:0] q;
   logic [31:0] mon_m;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int n_fail = 0;
   int samples_checked = 0;

   always #25 ref_clk_i = ~ref_clk_i;
   // Timer tick every fourth cycle
   always @(posedge ref_clk_i)
   begin
      tick_cnt <= tick_cnt + 2'h1;
      timer_tick_i <= (tick_cnt == 2'h3);
   end

   adcsc_top #(.CAL_CYCLES_P(CAL_SIM)) adcsc_top_i (.ref_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o, .timer_tick_i, .comp_i, .chan_mux_o,
      .dac_code_o, .sample_o, .power_down_o);
   adcsc_analog_model adcsc_analog_model_i (.ref_clk_i, .level_i(level), .chan_i(chan_mux_o), .dac_i(dac_code_o),
      .sample_i(sample_o), .comp_o(comp_i));

   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // One transfer, held until waitrequest is seen low; a read leaves a note
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [31:0] m);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      if (!wr)
      begin
         exp_q.push_back(d);
         msk_q.push_back(m);
      end
      do
      begin
         @(posedge ref_clk_i);
         n++;
      end
      while (avs_waitrequest_o !== 1'b0 && n < 20);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (n >= 20)
      begin
         n_fail++;
         final_report();
      end
      @(posedge ref_clk_i);
   endtask

   // Read until all masked bits are set, bounded
   task automatic poll(input logic [5:0] a, input logic [31:0] m);
      int n;
      n = 0;
      do
      begin
         bus(1'b0, a, 32'h0, 32'h0);
         n++;
      end
      while ((q & m) != m && n < 300);
      if (n >= 300)
      begin
         n_fail++;
         final_report();
      end
   endtask

   // Compare each read answer with the oldest note
   always @(posedge ref_clk_i)
      if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
      begin
         mon_m = msk_q.pop_front();
         chk(avs_readdata_o & mon_m, exp_q.pop_front() & mon_m);
      end

   initial
   begin
      logic ie;
      logic mk;
      void'($urandom(43));
      level <= {10'h000, 10'h3ff, 10'($urandom), 10'($urandom), 10'($urandom)};
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      // Reset values and an unmapped word
      bus(1'b0, OFS_CTRL_STATUS, {24'h0, RST_CTRL_STATUS}, 32'hffffffff);
      bus(1'b0, OFS_POWER_CTRL, 32'h1, 32'hffffffff);
      bus(1'b0, OFS_RESULT0, {16'h0, RST_RESULT}, 32'hffffffff);
      bus(1'b0, OFS_INT_MASK, 32'h0, 32'hffffffff);
      bus(1'b1, 6'h3c, 32'hffffffff, 32'h0);
      bus(1'b0, 6'h3c, 32'h0, 32'hffffffff);
      // Starts refused while powered down and while calibrating
      bus(1'b1, OFS_CTRL_STATUS, 32'h40, 32'h0);
      repeat (100) @(posedge ref_clk_i);
      bus(1'b0, OFS_CTRL_STATUS, 32'h0, 32'hc0);
      bus(1'b1, OFS_POWER_CTRL, 32'h0, 32'h0);
      bus(1'b0, OFS_POWER_CTRL, 32'h0, 32'h3);
      bus(1'b1, OFS_CTRL_STATUS, 32'h40, 32'h0);
      bus(1'b0, OFS_CTRL_STATUS, 32'h0, 32'h40);
      poll(OFS_POWER_CTRL, 32'h2);
      repeat (100) @(posedge ref_clk_i);
      bus(1'b0, OFS_CTRL_STATUS, 32'h0, 32'hc0);
      bus(1'b0, OFS_RESULT0, 32'h0, 32'hffffffff);
      // Every channel and clock code; irq enable and mask each turned off once
      for (int i = 0; i < NUM_CHAN; i++)
      begin
         ie = (i != 0);
         mk = (i != 3);
         bus(1'b1, OFS_INT_MASK, {31'h0, mk}, 32'h0);
         bus(1'b1, OFS_CTRL_STATUS, {24'h0, 2'b01, ie, 2'(i % 4), 3'(i)}, 32'h0);
         bus(1'b0, OFS_CTRL_STATUS, {24'h0, 2'b01, ie, 2'(i % 4), 3'(i)}, 32'h7f);
         poll(OFS_CTRL_STATUS, 32'h80);
         chk(q & 32'hc0, 32'h80);
         chk({31'h0, irq_o}, {31'h0, ie & mk});
         bus(1'b0, OFS_CTRL_STATUS, 32'h80, 32'h80);
         bus(1'b1, OFS_CTRL_STATUS, q & 32'h7f, 32'h0);
         bus(1'b0, OFS_CTRL_STATUS, 32'h0, 32'h80);
         bus(1'b0, OFS_RESULT0 + 6'(4 * i), {16'h0, level[i*RES_BITS +: RES_BITS], 6'h0}, 32'hffffffff);
         bus(1'b0, OFS_INT_STATUS, 32'h1, 32'h1);
         bus(1'b1, OFS_INT_STATUS, 32'h1, 32'h0);
         repeat (2) @(posedge ref_clk_i);
         chk({31'h0, irq_o}, 32'h0);
      end
      // Abort mid-conversion: no flag, old result kept
      level[RES_BITS-1:0] <= ~level[RES_BITS-1:0];
      bus(1'b1, OFS_CTRL_STATUS, 32'h40, 32'h0);
      bus(1'b1, OFS_CTRL_STATUS, 32'h00, 32'h0);
      repeat (120) @(posedge ref_clk_i);
      bus(1'b0, OFS_CTRL_STATUS, 32'h0, 32'hc0);
      bus(1'b0, OFS_RESULT0, {16'h0, ~level[RES_BITS-1:0], 6'h0}, 32'hffffffff);
      final_report();
   end
endmodule

bind adcsc_top adcsc_assertions adcsc_assertions_i (.ref_clk_i, .rst_i, .avs_read_i, .avs_write_i,
   .avs_waitrequest_o, .irq_o, .chan_mux_o, .dac_code_o, .sample_o, .power_down_o);
